// >>> src/sfrw_map.svh
`ifndef SFRW_MAP_SVH
`define SFRW_MAP_SVH
// ----------------------------------------
// command codes
// ----------------------------------------
`define SFRW_CMD_WSTAT 8'h01
`define SFRW_CMD_PROG 8'h02
`define SFRW_CMD_READ 8'h03
`define SFRW_CMD_WRDI 8'h04
`define SFRW_CMD_RDSR 8'h05
`define SFRW_CMD_WREN 8'h06
`define SFRW_CMD_FAST 8'h0b
`define SFRW_CMD_DOUT 8'h3b
`define SFRW_CMD_VWREN 8'h50
`define SFRW_CMD_RESET 8'h99
`define SFRW_CMD_DIO 8'hbb
// ----------------------------------------
// status byte layout and reset values
// ----------------------------------------
`define SFRW_ST_BUSY 0
`define SFRW_ST_WEL 1
`define SFRW_ST_BP_LO 2
`define SFRW_ST_TB 5
`define SFRW_ST_SRP 7
`define SFRW_PROT_RESET 5'h00
// ----------------------------------------
// frame geometry
// ----------------------------------------
`define SFRW_CMD_LAST 6'h07
`define SFRW_ADDR_LAST_1 6'h17
`define SFRW_ADDR_LAST_2 6'h0b
`define SFRW_MODE_LAST 6'h03
`define SFRW_DUMMY_LAST 6'h07
`define SFRW_CONT_KEY 2'b10
`define SFRW_BITS_CMD 6'h08
`define SFRW_BITS_WSTAT 6'h10
`define SFRW_BITS_PROG_MIN 6'h28
`define SFRW_BITS_SAT 6'h3f
`define SFRW_MEM_BYTES 262144
`define SFRW_PAGE_BYTES 256
`define SFRW_BLOCKS 3'h4
`define SFRW_ALL_BP 3'h3
// ----------------------------------------
// timing
// ----------------------------------------
`define SFRW_CLK_PERIOD_NS 50
`define SFRW_STATUS_WRITE_TIME_NS 10000000
`define SFRW_PROGRAM_TIME_NS 1000000
`define SFRW_CYCLES(t) (((t) + `SFRW_CLK_PERIOD_NS - 1) / `SFRW_CLK_PERIOD_NS)
`endif

// >>> src/sfrw_pkg.sv
`include "sfrw_map.svh"
package sfrw_pkg;
    typedef enum logic [2:0] {
        PH_START = 3'b000,
        PH_CMD = 3'b001,
        PH_ADDR = 3'b010,
        PH_MODE = 3'b011,
        PH_DUMMY = 3'b100,
        PH_DIN = 3'b101,
        PH_DOUT = 3'b110,
        PH_IGNORE = 3'b111
    } sfrw_phase_type;

    typedef enum logic [1:0] {
        CORE_IDLE = 2'b00,
        CORE_WALK = 2'b01,
        CORE_WAIT = 2'b10
    } sfrw_core_type;

    // block-granular protection, top or bottom
    function automatic logic sfrw_prot_hit(input logic [23:0] addr, input logic tb,
                                           input logic [2:0] bp);
        logic [2:0] nblk;
        logic [2:0] blk;
        nblk = (bp >= `SFRW_ALL_BP) ? `SFRW_BLOCKS : bp;
        blk = {1'b0, addr[17:16]};
        if (tb) begin
            return blk < nblk;
        end
        return (blk + nblk) >= `SFRW_BLOCKS;
    endfunction

    function automatic logic sfrw_is_read(input logic [7:0] c);
        return c == `SFRW_CMD_READ || c == `SFRW_CMD_FAST || c == `SFRW_CMD_DOUT
            || c == `SFRW_CMD_DIO;
    endfunction
endpackage

// >>> src/sfrw_sync.sv
`timescale 1ns/1ps
module sfrw_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk_in,
    input wire logic arst_n_in,
    input wire logic [WIDTH-1:0] d_in,
    output logic [WIDTH-1:0] q_out
);
    logic [WIDTH-1:0] meta_reg;

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            meta_reg <= '0;
            q_out <= '0;
        end else begin
            meta_reg <= d_in;
            q_out <= meta_reg;
        end
    end
endmodule // sfrw_sync

// >>> src/sfrw_timer.sv
`timescale 1ns/1ps
module sfrw_timer (
    input wire logic mclk_in,
    input wire logic arst_n_in,
    sfrw_timer_if.timer tif
);
    logic [31:0] cnt_reg;
    logic busy_reg;

    assign tif.busy = busy_reg;
    assign tif.done = busy_reg && (cnt_reg == 32'h1);

    always_ff @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            cnt_reg <= 32'h0;
            busy_reg <= 1'b0;
        end else if (tif.start && !busy_reg) begin
            cnt_reg <= tif.cycles;
            busy_reg <= 1'b1;
        end else if (tif.done) begin
            busy_reg <= 1'b0;
        end else if (busy_reg) begin
            cnt_reg <= cnt_reg - 32'h1;
        end
    end
endmodule // sfrw_timer

// >>> src/sfrw_timer_if.sv
`timescale 1ns/1ps
interface sfrw_timer_if;
    logic start;
    logic [31:0] cycles;
    logic busy;
    logic done;
    modport timer(input start, input cycles, output busy, output done);
    modport core(output start, output cycles, input busy, input done);
endinterface

// >>> src/sfrw_top.sv
`timescale 1ns/1ps
`include "sfrw_map.svh"
// Operation
// RULE_01 - status write alters only protect, top-bottom and block-protect bits
// RULE_02 - non-volatile status write needs write-enable latch set beforehand
// RULE_03 - volatile enable before status write makes values volatile, latch stays clear
// RULE_04 - reset command or power loss restores stored non-volatile status values; arst_n_in instead loads SFRW_PROT_RESET into them
// RULE_05 - status write executes only if frame ends after exactly sixteen bits
// RULE_06 - non-volatile status write runs timed cycle, busy set, then clears latch
// RULE_07 - volatile status write updates bits promptly with busy staying clear
// RULE_08 - read-status command keeps working during a busy cycle
// RULE_09 - plain read: command and address in on rise, data out MSB-first on fall
// RULE_10 - reads advance the address per byte until chip select rises
// RULE_11 - read command while busy is ignored without touching the cycle
// RULE_12 - fast read has eight dummy clocks whose input is ignored
// RULE_13 - dual-output read adds dummy clocks, then two bits per clock
// RULE_14 - host releases data lines before first output falling edge
// RULE_15 - dual I/O read takes address and mode bits two per clock
// RULE_16 - mode bits 5:4 equal 10 skip the command byte next frame
// RULE_17 - host may send all ones on line zero to leave continuous mode
// RULE_18 - page program needs latch set, address and one to 256 bytes
// RULE_19 - program data wraps within the page, later bytes replace earlier
// RULE_20 - program executes only if frame ends on a byte boundary
// RULE_21 - valid program runs timed cycle with busy, then clears busy and latch
// RULE_22 - program into a protected region is not executed
// RULE_23 - dual output: line one odd bits, line zero even bits, MSB first
// RULE_24 - dual address: line one odd bits, line zero even bits
// RULE_25 - write-enable sets the latch, write-disable clears it
// RULE_26 - continuous read mode is off after power-up
module sfrw_top #(
    parameter int unsigned STATUS_WRITE_CYCLES = `SFRW_CYCLES(`SFRW_STATUS_WRITE_TIME_NS),
    parameter int unsigned PROGRAM_CYCLES = `SFRW_CYCLES(`SFRW_PROGRAM_TIME_NS)
) (
    input wire logic mclk_in,
    input wire logic arst_n_in,
    input wire logic sclk_in,
    input wire logic chip_select_n_in,
    input wire logic data_line_zero_in,
    input wire logic data_line_one_in,
    output logic data_line_zero_out,
    output logic data_line_zero_oe_out,
    output logic data_line_one_out,
    output logic data_line_one_oe_out,
    output logic busy_flag_out,
    output logic write_enable_latch_out,
    output logic status_protect_bit_out,
    output logic top_bottom_select_out,
    output logic [2:0] block_protect_out,
    output logic execute_in_place_out
);
    // ----------------------------------------
    // shared storage
    // ----------------------------------------
    logic [7:0] flash_mem [0:`SFRW_MEM_BYTES-1];
    logic [7:0] page_buf [0:`SFRW_PAGE_BYTES-1];
    logic [`SFRW_PAGE_BYTES-1:0] mask_reg;

    initial begin
        for (int i = 0; i < `SFRW_MEM_BYTES; i++) begin
            flash_mem[i] = 8'hff;
        end
    end

    // ----------------------------------------
    // link domain
    // ----------------------------------------
    sfrw_pkg::sfrw_phase_type phase_reg;
    sfrw_pkg::sfrw_phase_type phase_next;
    sfrw_pkg::sfrw_phase_type cur_phase;
    logic [5:0] cnt_reg;
    logic [5:0] cnt_next;
    logic [7:0] cmd_reg;
    logic [7:0] cmd_next;
    logic [23:0] addr_reg;
    logic [23:0] addr_next;
    logic [7:0] shift_reg;
    logic [7:0] shift_next;
    logic [2:0] out_bit_reg;
    logic [2:0] out_bit_next;
    logic [5:0] bits_reg;
    logic [2:0] bitmod_reg;
    logic cont_mode_reg;
    logic cont_next;
    logic frame_tog_reg;
    logic pb_we;
    logic mask_clr;
    logic [7:0] status_byte_reg;
    logic [7:0] status_l;

    wire frame_rst_n = arst_n_in & ~chip_select_n_in;
    wire first_edge = (phase_reg == sfrw_pkg::PH_START);
    wire [7:0] cur_cmd = (first_edge && cont_mode_reg) ? `SFRW_CMD_DIO : cmd_reg;
    wire [5:0] cnt_cur = first_edge ? 6'h0 : cnt_reg;
    wire [5:0] bits_cur = first_edge ? 6'h0 : bits_reg;
    wire [2:0] bitmod_cur = first_edge ? 3'h0 : bitmod_reg;
    wire busy_l = status_l[`SFRW_ST_BUSY];
    wire [1:0] din2 = {data_line_one_in, data_line_zero_in}; // [RULE_24]
    wire dual_io = (cur_cmd == `SFRW_CMD_DIO);
    wire dual_out = dual_io || (cur_cmd == `SFRW_CMD_DOUT);
    wire [2:0] out_step = dual_out ? 3'h2 : 3'h1;
    wire [7:0] out_byte = (cmd_reg == `SFRW_CMD_RDSR) ? status_l : flash_mem[addr_reg[17:0]];
    wire [2:0] bit_hi = 3'h7 - out_bit_reg;
    wire [2:0] bit_lo = bit_hi - 3'h1;

    assign cur_phase = first_edge ? (cont_mode_reg ? sfrw_pkg::PH_ADDR : sfrw_pkg::PH_CMD)
                                  : phase_reg; // [RULE_16]

    sfrw_sync #(.WIDTH(8)) u_status_sync (
        .clk_in(sclk_in),
        .arst_n_in(arst_n_in),
        .d_in(status_byte_reg),
        .q_out(status_l)
    );

    function automatic sfrw_pkg::sfrw_phase_type after_cmd(input logic [7:0] c, input logic b);
        if (sfrw_pkg::sfrw_is_read(c)) begin
            return b ? sfrw_pkg::PH_IGNORE : sfrw_pkg::PH_ADDR; // [RULE_11]
        end
        unique case (c)
            `SFRW_CMD_PROG: return sfrw_pkg::PH_ADDR;
            `SFRW_CMD_WSTAT: return sfrw_pkg::PH_DIN;
            `SFRW_CMD_RDSR: return sfrw_pkg::PH_DOUT; // [RULE_08]
            default: return sfrw_pkg::PH_IGNORE;
        endcase
    endfunction

    function automatic sfrw_pkg::sfrw_phase_type after_addr(input logic [7:0] c);
        unique case (c)
            `SFRW_CMD_READ: return sfrw_pkg::PH_DOUT;
            `SFRW_CMD_FAST, `SFRW_CMD_DOUT: return sfrw_pkg::PH_DUMMY;
            `SFRW_CMD_DIO: return sfrw_pkg::PH_MODE;
            `SFRW_CMD_PROG: return sfrw_pkg::PH_DIN;
            default: return sfrw_pkg::PH_IGNORE;
        endcase
    endfunction

    always_comb begin
        phase_next = cur_phase;
        cnt_next = cnt_cur + 6'h1;
        cmd_next = cur_cmd;
        addr_next = addr_reg;
        shift_next = {shift_reg[6:0], data_line_zero_in};
        out_bit_next = 3'h0;
        cont_next = cont_mode_reg;
        pb_we = 1'b0;
        mask_clr = 1'b0;
        unique case (cur_phase)
            sfrw_pkg::PH_CMD: begin
                if (cnt_cur == `SFRW_CMD_LAST) begin
                    cmd_next = shift_next;
                    cnt_next = 6'h0;
                    phase_next = after_cmd(shift_next, busy_l);
                    mask_clr = (shift_next == `SFRW_CMD_PROG) && !busy_l;
                end
            end
            sfrw_pkg::PH_ADDR: begin
                if (dual_io) begin
                    addr_next = {addr_reg[21:0], din2}; // [RULE_15]
                end else begin
                    addr_next = {addr_reg[22:0], data_line_zero_in}; // [RULE_09]
                end
                if (cnt_cur == (dual_io ? `SFRW_ADDR_LAST_2 : `SFRW_ADDR_LAST_1)) begin
                    cnt_next = 6'h0;
                    phase_next = after_addr(cur_cmd);
                end
            end
            sfrw_pkg::PH_MODE: begin
                shift_next = {shift_reg[5:0], din2};
                if (cnt_cur == `SFRW_MODE_LAST) begin
                    cont_next = (shift_next[5:4] == `SFRW_CONT_KEY); // [RULE_16] [RULE_17]
                    cnt_next = 6'h0;
                    phase_next = sfrw_pkg::PH_DOUT;
                end
            end
            sfrw_pkg::PH_DUMMY: begin
                if (cnt_cur == `SFRW_DUMMY_LAST) begin // [RULE_12] [RULE_13]
                    cnt_next = 6'h0;
                    phase_next = sfrw_pkg::PH_DOUT;
                end
            end
            sfrw_pkg::PH_DIN: begin
                if (cnt_cur == `SFRW_CMD_LAST) begin
                    cnt_next = 6'h0;
                    if (cur_cmd == `SFRW_CMD_PROG && !busy_l) begin
                        pb_we = 1'b1;
                        addr_next[7:0] = addr_reg[7:0] + 8'h1; // [RULE_19]
                    end
                end
            end
            sfrw_pkg::PH_DOUT: begin
                out_bit_next = out_bit_reg + out_step;
                if (out_bit_next == 3'h0 && cur_cmd != `SFRW_CMD_RDSR) begin
                    addr_next = addr_reg + 24'h1; // [RULE_10]
                end
            end
            sfrw_pkg::PH_START, sfrw_pkg::PH_IGNORE: begin
                cnt_next = cnt_cur;
            end
        endcase
    end

    always_ff @(posedge sclk_in or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            phase_reg <= sfrw_pkg::PH_START;
        end else begin
            phase_reg <= phase_next;
        end
    end

    always_ff @(posedge sclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            cnt_reg <= 6'h0;
            cmd_reg <= 8'h0;
            addr_reg <= 24'h0;
            shift_reg <= 8'h0;
            out_bit_reg <= 3'h0;
            bits_reg <= 6'h0;
            bitmod_reg <= 3'h0;
            cont_mode_reg <= 1'b0; // [RULE_26]
            frame_tog_reg <= 1'b0;
            execute_in_place_out <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            cmd_reg <= cmd_next;
            addr_reg <= addr_next;
            shift_reg <= shift_next;
            out_bit_reg <= out_bit_next;
            bits_reg <= (bits_cur == `SFRW_BITS_SAT) ? bits_cur : bits_cur + 6'h1;
            bitmod_reg <= bitmod_cur + 3'h1;
            cont_mode_reg <= cont_next;
            frame_tog_reg <= frame_tog_reg ^ first_edge;
            execute_in_place_out <= cont_next;
        end
    end

    always_ff @(posedge sclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            mask_reg <= '0;
        end else if (mask_clr) begin
            mask_reg <= '0;
        end else if (pb_we) begin
            mask_reg[addr_reg[7:0]] <= 1'b1;
        end
    end

    always_ff @(posedge sclk_in) begin
        if (pb_we) begin
            page_buf[addr_reg[7:0]] <= shift_next; // [RULE_19]
        end
    end

    // outputs change on the falling edge, released when the frame ends
    always_ff @(negedge sclk_in or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            data_line_zero_out <= 1'b0;
            data_line_zero_oe_out <= 1'b0;
            data_line_one_out <= 1'b0;
            data_line_one_oe_out <= 1'b0;
        end else if (phase_reg == sfrw_pkg::PH_DOUT) begin
            data_line_one_out <= out_byte[bit_hi]; // [RULE_09] [RULE_23]
            data_line_one_oe_out <= 1'b1;
            data_line_zero_out <= dual_out ? out_byte[bit_lo] : 1'b0; // [RULE_23]
            data_line_zero_oe_out <= dual_out; // [RULE_13] [RULE_14]
        end
    end

    // ----------------------------------------
    // core domain
    // ----------------------------------------
    sfrw_timer_if tif ();
    sfrw_pkg::sfrw_core_type core_reg;
    logic cs_s;
    logic cs_d_reg;
    logic seen_tog_reg;
    logic wel_reg;
    logic vol_en_reg;
    logic job_prog_reg;
    logic [4:0] nv_prot_reg;
    logic [4:0] prot_reg;
    logic [4:0] pend_prot_reg;
    logic [7:0] walk_reg;

    sfrw_sync #(.WIDTH(1)) u_cs_sync (
        .clk_in(mclk_in),
        .arst_n_in(arst_n_in),
        .d_in(chip_select_n_in),
        .q_out(cs_s)
    );

    sfrw_timer u_timer (
        .mclk_in(mclk_in),
        .arst_n_in(arst_n_in),
        .tif(tif)
    );

    // link registers are still while chip select is high
    wire new_frame = cs_s && !cs_d_reg && (frame_tog_reg != seen_tog_reg);
    wire idle = new_frame && !tif.busy && (core_reg == sfrw_pkg::CORE_IDLE);
    wire exact8 = (bits_reg == `SFRW_BITS_CMD);
    wire is_wren = idle && exact8 && cmd_reg == `SFRW_CMD_WREN;
    wire is_wrdi = idle && exact8 && cmd_reg == `SFRW_CMD_WRDI;
    wire is_vwren = idle && exact8 && cmd_reg == `SFRW_CMD_VWREN;
    wire is_reset = idle && exact8 && cmd_reg == `SFRW_CMD_RESET;
    wire is_wstat = idle && bits_reg == `SFRW_BITS_WSTAT && cmd_reg == `SFRW_CMD_WSTAT; // [RULE_05]
    wire vol_go = is_wstat && vol_en_reg; // [RULE_03]
    wire nv_go = is_wstat && !vol_en_reg && wel_reg; // [RULE_02]
    wire prot_hit = sfrw_pkg::sfrw_prot_hit(addr_reg, prot_reg[3], prot_reg[2:0]);
    wire prog_go = idle && cmd_reg == `SFRW_CMD_PROG && wel_reg // [RULE_18]
                   && bitmod_reg == 3'h0 && bits_reg >= `SFRW_BITS_PROG_MIN // [RULE_20]
                   && !prot_hit; // [RULE_22]
    wire [4:0] wr_prot = {shift_reg[`SFRW_ST_SRP], shift_reg[`SFRW_ST_TB],
                          shift_reg[`SFRW_ST_BP_LO+2:`SFRW_ST_BP_LO]}; // [RULE_01]
    wire [17:0] walk_addr = {addr_reg[17:8], walk_reg};
    wire walk_we = (core_reg == sfrw_pkg::CORE_WALK) && mask_reg[walk_reg];

    assign tif.start = prog_go || nv_go; // [RULE_06] [RULE_21]
    assign tif.cycles = prog_go ? PROGRAM_CYCLES : STATUS_WRITE_CYCLES;
    assign busy_flag_out = tif.busy;
    assign write_enable_latch_out = wel_reg;
    assign status_protect_bit_out = prot_reg[4];
    assign top_bottom_select_out = prot_reg[3];
    assign block_protect_out = prot_reg[2:0];

    always_ff @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            cs_d_reg <= 1'b1;
            seen_tog_reg <= 1'b0;
            vol_en_reg <= 1'b0;
            status_byte_reg <= 8'h0;
        end else begin
            cs_d_reg <= cs_s;
            seen_tog_reg <= new_frame ? frame_tog_reg : seen_tog_reg;
            vol_en_reg <= new_frame ? is_vwren : vol_en_reg; // [RULE_03]
            status_byte_reg <= {prot_reg[4], 1'b0, prot_reg[3], prot_reg[2:0],
                                wel_reg, tif.busy};
        end
    end

    always_ff @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            core_reg <= sfrw_pkg::CORE_IDLE;
            wel_reg <= 1'b0;
            job_prog_reg <= 1'b0;
            nv_prot_reg <= `SFRW_PROT_RESET; // [RULE_04]
            prot_reg <= `SFRW_PROT_RESET;
            pend_prot_reg <= `SFRW_PROT_RESET;
            walk_reg <= 8'h0;
        end else begin
            unique case (core_reg)
                sfrw_pkg::CORE_IDLE: begin
                    if (is_wren) begin
                        wel_reg <= 1'b1; // [RULE_25]
                    end else if (is_wrdi) begin
                        wel_reg <= 1'b0; // [RULE_25]
                    end else if (is_reset) begin
                        prot_reg <= nv_prot_reg; // [RULE_04]
                        wel_reg <= 1'b0;
                    end else if (vol_go) begin
                        prot_reg <= wr_prot; // [RULE_07]
                    end else if (nv_go) begin
                        pend_prot_reg <= wr_prot;
                        job_prog_reg <= 1'b0;
                        core_reg <= sfrw_pkg::CORE_WAIT;
                    end else if (prog_go) begin
                        job_prog_reg <= 1'b1;
                        walk_reg <= 8'h0;
                        core_reg <= sfrw_pkg::CORE_WALK;
                    end
                end
                sfrw_pkg::CORE_WALK: begin
                    walk_reg <= walk_reg + 8'h1;
                    if (walk_reg == 8'hff) begin
                        core_reg <= sfrw_pkg::CORE_WAIT;
                    end
                end
                sfrw_pkg::CORE_WAIT: begin
                    if (tif.done) begin
                        wel_reg <= 1'b0; // [RULE_06] [RULE_21]
                        if (!job_prog_reg) begin
                            nv_prot_reg <= pend_prot_reg;
                            prot_reg <= pend_prot_reg;
                        end
                        core_reg <= sfrw_pkg::CORE_IDLE;
                    end
                end
                default: core_reg <= sfrw_pkg::CORE_IDLE;
            endcase
        end
    end

    // programming only clears bits, one page byte per cycle
    always_ff @(posedge mclk_in) begin
        if (walk_we) begin
            flash_mem[walk_addr] <= flash_mem[walk_addr] & page_buf[walk_reg];
        end
    end
endmodule // sfrw_top

// >>> test/sfrw_host.sv
`timescale 1ns/1ps
module sfrw_host (
    output logic sclk_out,
    output logic cs_n_out,
    output logic d0_out,
    output logic d1_out,
    input wire logic d0_in,
    input wire logic d1_in
);
    initial begin
        sclk_out = 1'b0;
        cs_n_out = 1'b1;
        d0_out = 1'b1;
        d1_out = 1'b0;
    end
    // mode 0, clock still between frames
    // last 2*npair tx bits go two per clock, odd bit on lane one
    task automatic frame(input logic [63:0] tx, input int ntx, input int nrx,
                         input bit dual, input int npair, output logic [63:0] rx);
        rx = '0;
        cs_n_out = 1'b0;
        for (int i = ntx - 1; i >= 0; i = i - 1 - int'(i < 2 * npair)) begin
            d1_out = tx[i];
            d0_out = (i < 2 * npair) ? tx[i - 1] : tx[i];
            #62.5 sclk_out = 1'b1;
            #62.5 sclk_out = 1'b0;
        end
        for (int i = 0; i < nrx; i++) begin
            d0_out = ~d0_out; // released lanes show noise
            d1_out = ~d1_out;
            #62.5 sclk_out = 1'b1;
            rx = dual ? {rx[61:0], d1_in, d0_in} : {rx[62:0], d1_in};
            #62.5 sclk_out = 1'b0;
        end
        #20 cs_n_out = 1'b1; // select rises right after last bit
        #400;
    endtask
endmodule // sfrw_host

// >>> test/sfrw_monitor.sv
`timescale 1ns/1ps
module sfrw_monitor #(
    parameter int PROG_CYC = 300,
    parameter int SW_CYC = 400
) (
    input wire logic mclk_in,
    input wire logic arst_n_in,
    input wire logic chip_select_n_in,
    input wire logic data_line_zero_oe_out,
    input wire logic data_line_one_oe_out,
    input wire logic busy_flag_out,
    input wire logic write_enable_latch_out,
    input wire logic status_protect_bit_out,
    input wire logic top_bottom_select_out,
    input wire logic [2:0] block_protect_out
);
    logic [15:0] cnt_reg;
    always_ff @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) cnt_reg <= 16'h0000;
        else cnt_reg <= busy_flag_out ? cnt_reg + 16'h0001 : 16'h0000;
    end
    default clocking @(posedge mclk_in); endclocking
    default disable iff (!arst_n_in);
    a_oe_idle: assert property (chip_select_n_in |-> !data_line_one_oe_out)
        else $error("data output enabled outside a frame");
    a_dual_pair: assert property (data_line_zero_oe_out |-> data_line_one_oe_out)
        else $error("lane zero driven without lane one");
    a_busy_length: assert property ($fell(busy_flag_out) |->
        cnt_reg >= PROG_CYC - 2 && cnt_reg <= SW_CYC + 2) else $error("busy length wrong");
    a_latch_end: assert property ($fell(busy_flag_out) |-> ##[0:2] !write_enable_latch_out)
        else $error("latch not cleared after cycle");
    a_busy_enabled: assert property ($rose(busy_flag_out) |-> write_enable_latch_out)
        else $error("cycle started without latch");
    a_busy_after_cs: assert property ($rose(busy_flag_out) |-> chip_select_n_in)
        else $error("cycle started inside a frame");
    a_fields_hold: assert property (busy_flag_out && $past(busy_flag_out) |->
        $stable({status_protect_bit_out, top_bottom_select_out, block_protect_out}))
        else $error("protection changed during cycle");
    a_latch_rise: assert property ($rose(write_enable_latch_out) |-> chip_select_n_in)
        else $error("latch set inside a frame");
endmodule // sfrw_monitor

bind sfrw_top sfrw_monitor #(.PROG_CYC(PROGRAM_CYCLES), .SW_CYC(STATUS_WRITE_CYCLES))
    u_sfrw_monitor (.mclk_in(mclk_in), .arst_n_in(arst_n_in),
    .chip_select_n_in(chip_select_n_in), .data_line_zero_oe_out(data_line_zero_oe_out),
    .data_line_one_oe_out(data_line_one_oe_out), .busy_flag_out(busy_flag_out),
    .write_enable_latch_out(write_enable_latch_out),
    .status_protect_bit_out(status_protect_bit_out),
    .top_bottom_select_out(top_bottom_select_out), .block_protect_out(block_protect_out));

// >>> test/sfrw_tb_top.sv
`timescale 1ns/1ps
module sfrw_tb_top;
    logic mclk_in = 1'b0;
    logic arst_n_in = 1'b0;
    logic sclk, csn, h0, h1, d0o, d0e, d1o, d1e, busy, write_enable_latch, status_protect_bit, tbs, execute_in_place;
    logic [2:0] bp;
    logic [63:0] rx;
    logic [23:0] pa;
    logic [7:0] v, b1, b2;
    int err_total = 0;
    int num_checks = 0;
    wire logic d0 = d0e ? d0o : h0;
    wire logic d1 = d1e ? d1o : h1;
    initial forever #25 mclk_in = ~mclk_in;
    sfrw_top #(.STATUS_WRITE_CYCLES(400), .PROGRAM_CYCLES(300)) u_sfrw_top (
        .mclk_in(mclk_in), .arst_n_in(arst_n_in), .sclk_in(sclk), .chip_select_n_in(csn),
        .data_line_zero_in(d0), .data_line_one_in(d1), .data_line_zero_out(d0o),
        .data_line_zero_oe_out(d0e), .data_line_one_out(d1o), .data_line_one_oe_out(d1e),
        .busy_flag_out(busy), .write_enable_latch_out(write_enable_latch), .status_protect_bit_out(status_protect_bit),
        .top_bottom_select_out(tbs), .block_protect_out(bp), .execute_in_place_out(execute_in_place));
    sfrw_host u_sfrw_host (.sclk_out(sclk), .cs_n_out(csn), .d0_out(h0), .d1_out(h1),
        .d0_in(d0), .d1_in(d1));
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        num_checks++;
        if (g !== e) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic summarize();
        if (err_total == 0 && num_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic fr(input logic [63:0] tx, input int n, input int r = 0, input bit du = 0,
                      input int p = 0);
        u_sfrw_host.frame(tx, n, r, du, p, rx);
    endtask
    task automatic idle();
        for (int i = 0; i < 2000 && busy === 1'b1; i++) @(posedge mclk_in);
        if (busy !== 1'b0) begin
            err_total++;
            summarize();
        end
    endtask
    function automatic logic [7:0] st(input logic [7:0] p, input logic w, input logic b);
        return {p[7], 1'b0, p[5:2], w, b};
    endfunction
    initial begin
        v = $urandom(32'h97d40b6b);
        repeat (5) @(posedge mclk_in);
        arst_n_in <= 1'b1;
        repeat (3) @(posedge mclk_in);
        chk("after reset", 16'h0, {busy, write_enable_latch, status_protect_bit, tbs, bp, execute_in_place});
        fr(8'h06, 8);
        chk("latch set", 16'h1, write_enable_latch);
        fr({8'h01, 8'h9c, 1'b0}, 17);
        chk("long write", 16'h0, {busy, status_protect_bit, tbs, bp});
        fr(8'h04, 8);
        chk("latch clear", 16'h0, write_enable_latch);
        v = ($urandom & 8'he3) | 8'h04;
        fr(8'h06, 8);
        fr({8'h01, v}, 16);
        fr(8'h05, 8, 8);
        chk("status busy", st(8'h00, 1'b1, 1'b1), rx[7:0]);
        idle();
        chk("nv write", {v[7], v[5], v[4:2], 2'b00}, {status_protect_bit, tbs, bp, write_enable_latch, busy});
        pa = {6'h00, 2'h1 + 2'($urandom % 2), 8'($urandom), 8'hff};
        b1 = $urandom;
        b2 = $urandom;
        fr(8'h06, 8);
        fr({8'h02, pa, b1, b2}, 48);
        fr({8'h03, pa}, 32, 8);
        chk("busy kept", 16'h3, {busy, write_enable_latch});
        idle();
        chk("program end", 16'h0, {busy, write_enable_latch});
        fr({8'h03, pa}, 32, 16);
        chk("read", {b1, 8'hff}, rx[15:0]);
        fr({8'h0b, pa[23:8], 8'h00, 8'($urandom)}, 40, 8);
        chk("fast read", b2, rx[7:0]);
        fr({8'h3b, pa, 8'($urandom)}, 40, 4, 1);
        chk("dual read", b1, rx[7:0]);
        fr({8'hbb, pa, 8'h20 | 8'($urandom % 16)}, 40, 4, 1, 16);
        chk("dual io", {b1, 1'b1}, {rx[7:0], execute_in_place});
        fr({pa[23:8], 8'h00, 8'hff}, 32, 4, 1, 16);
        chk("continuous", {b2, 1'b0}, {rx[7:0], execute_in_place});
        fr(8'h06, 8);
        fr({8'h02, 6'h00, v[5] ? 2'h0 : 2'h3, 16'h0000, b1}, 40);
        chk("protected", 16'h0, busy);
        fr(8'h04, 8);
        fr(8'h50, 8);
        fr({8'h01, ~v}, 16);
        chk("volatile", {~v[7], ~v[5], ~v[4:2], 2'b00}, {status_protect_bit, tbs, bp, write_enable_latch, busy});
        fr(8'h99, 8);
        chk("restore", {v[7], v[5], v[4:2]}, {status_protect_bit, tbs, bp});
        summarize();
    end
endmodule // sfrw_tb_top
